// ### rtl/tpw_chan.sv
/*
 * One timer channel: count clock selection, 16-bit up counter and the
 * two compare-match detectors with the counter clear selection.
 * Assumes prescaler phase and external edge pulses come from the top.
 */
`timescale 1ns/1ps
module tpw_chan
	import tpw_pkg::*;
#(
	parameter int W = TPW_W
) (
	input  wire logic          ref_clk,
	input  wire logic          rst,
	input  wire logic [6:0]    ctrl,
	input  wire logic [2:0]    pre,
	input  wire logic [3:0]    ext_rise,
	input  wire logic [3:0]    ext_fall,
	input  wire logic          run,
	input  wire logic          force_clr_a,
	input  wire logic          sync_clr_in,
	input  wire logic          cnt_wr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [W-1:0]  general_reg_a,
	input  wire logic [W-1:0]  general_reg_b,
	output logic      [W-1:0]  cnt,
	output logic               tick,
	output logic               match_a,
	output logic               match_b,
	output logic               clr_own
);

	// ==========================================================
	// Count clock selection
	// ==========================================================
	wire logic [2:0] clk_sel  = ctrl[TPW_CLK_LSB +: 3];
	wire logic [1:0] edge_sel = ctrl[TPW_EDGE_LSB +: 2];
	wire tpw_clr_t   clr_sel  = force_clr_a ? TPW_CLR_A : tpw_clr_t'(ctrl[TPW_CLR_LSB +: 2]);

	// Internal rates: system clock, then divide by 2, 4 and 8.
	wire logic int_tick = (clk_sel[1:0] == 2'h0) ? 1'b1 :
	                      (clk_sel[1:0] == 2'h1) ? pre[0] :
	                      (clk_sel[1:0] == 2'h2) ? &pre[1:0] : &pre;
	wire logic e_r = ext_rise[clk_sel[1:0]];
	wire logic e_f = ext_fall[clk_sel[1:0]];
	// The edge field picks which external transitions count.
	wire logic ext_tick = (edge_sel == TPW_EDGE_RISE) ? e_r :
	                      (edge_sel == TPW_EDGE_FALL) ? e_f : (e_r | e_f);
	assign tick = run & (clk_sel[2] ? ext_tick : int_tick);

	// ==========================================================
	// Compare and clear
	// ==========================================================
	// A match fires on the count edge that leaves the matching value.
	assign match_a = tick & (cnt == general_reg_a);
	assign match_b = tick & (cnt == general_reg_b);
	assign clr_own = ((clr_sel == TPW_CLR_A) & match_a) | ((clr_sel == TPW_CLR_B) & match_b);
	wire logic clr = clr_own | ((clr_sel == TPW_CLR_SYNC) & sync_clr_in);

	wire logic [W-1:0] next_cnt = cnt_wr ? wdata : clr ? '0 : tick ? W'(cnt + 1'b1) : cnt;

	// Counter register; a software write wins over counting.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt <= TPW_CNT_RST;
		end else begin
			cnt <= next_cnt;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_clear_on_match: assert property ((clr_own && !cnt_wr) |=> cnt == '0)
		else $error("counter not cleared after selected match");
	chk_count_step: assert property ((tick && !clr && !cnt_wr) |=> cnt == W'($past(cnt) + 1'b1))
		else $error("counter did not step on count tick");

endmodule : tpw_chan

// ### rtl/tpw_pkg.sv
/*
 * Constants and types shared by the timer PWM output block: register
 * offsets, field positions, reset values and mode encodings.
 * Assumes a single 20 MHz clock domain and a plain register port.
 */
package tpw_pkg;

	// ==========================================================
	// Sizes
	// ==========================================================
	localparam int TPW_W      = 16;  // Counter and general register width.
	localparam int TPW_NCH    = 5;   // Number of timer channels.
	localparam int TPW_ADDR_W = 6;   // Register port address width.
	localparam int TPW_NEXT   = 4;   // Number of external count inputs.

	// ==========================================================
	// Register offsets (word addresses)
	// ==========================================================
	localparam logic [2:0] TPW_OFF_CTRL  = 3'h0;  // timer_control_reg, per channel.
	localparam logic [2:0] TPW_OFF_IO    = 3'h1;  // io_control_reg, per channel.
	localparam logic [2:0] TPW_OFF_CNT   = 3'h2;  // timer_count, per channel.
	localparam logic [2:0] TPW_OFF_GRA   = 3'h3;  // general_reg_a, per channel.
	localparam logic [2:0] TPW_OFF_GRB   = 3'h4;  // general_reg_b, per channel.
	localparam logic [5:0] TPW_OFF_START = 6'h28; // timer_start_reg.
	localparam logic [5:0] TPW_OFF_MODE  = 6'h29; // timer_mode_reg, one PWM bit per channel.
	localparam logic [5:0] TPW_OFF_COMB  = 6'h2A; // combination_mode_reg.

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int TPW_CLK_LSB  = 0;  // count_clock_select, 3 bits.
	localparam int TPW_EDGE_LSB = 3;  // ext_edge_select_hi/lo, 2 bits.
	localparam int TPW_CLR_LSB  = 5;  // counter_clear_select_hi/lo, 2 bits.
	localparam int TPW_IOB_LSB  = 0;  // pin_b_function_hi/lo, 2 bits.
	localparam int TPW_IOA_LSB  = 2;  // Pin A compare function, 2 bits.

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [6:0]        TPW_CTRL_RST = 7'h00;
	localparam logic [3:0]        TPW_IO_RST   = 4'h0;
	localparam logic [TPW_W-1:0]  TPW_GR_RST   = 16'hFFFF;
	localparam logic [TPW_W-1:0]  TPW_CNT_RST  = 16'h0000;

	// ==========================================================
	// Encodings
	// ==========================================================
	typedef enum logic [1:0] {
		TPW_CLR_NONE = 2'b00,
		TPW_CLR_A    = 2'b01,
		TPW_CLR_B    = 2'b10,
		TPW_CLR_SYNC = 2'b11
	} tpw_clr_t;

	typedef enum logic [1:0] {
		TPW_CMB_NORMAL = 2'b00,
		TPW_CMB_RSYNC  = 2'b01,
		TPW_CMB_COMPL  = 2'b10,
		TPW_CMB_RSV    = 2'b11
	} tpw_cmb_t;

	typedef enum logic [1:0] {
		TPW_OF_NONE   = 2'b00,
		TPW_OF_ZERO   = 2'b01,
		TPW_OF_ONE    = 2'b10,
		TPW_OF_TOGGLE = 2'b11
	} tpw_of_t;

	localparam logic [1:0] TPW_EDGE_RISE = 2'b00; // Other codes: 01 fall, 1x both.
	localparam logic [1:0] TPW_EDGE_FALL = 2'b01;

endpackage : tpw_pkg

// ### rtl/tpw_top.sv
/*
 * Timer PWM output block: five channels with PWM mode, per-pin compare
 * outputs and the channel 3/4 pair modes, reached over a plain register port.
 * Assumes all inputs are synchronous to ref_clk and the master never
 * issues read and write strobes together.
 */
// The implementer's own choices: the address-and-strobe port and the register offsets.
// How it works
// - PWM bit makes A/B compares, pin A outputs
// - Pin B keeps its own function in PWM
// - Match A drives high, match B drives low
// - Clear source is match A or match B
// - Clear on B, A above B: 0% duty
// - Clear on A, B above A: 100% duty
// - External edges chosen by edge field
// - Reset-sync mode: six PWM pins, counter 3 up
// - Pairs on fixed pins, second pin inverted
// - Counter 4 free; A4, B4 compare counter 3
// - Counter 3 clears on A3 match
// - Outputs toggle at turn match and clear
// - Complementary mode: six PWM pins, both counters (here all pairs follow counter 3 only)
// - Complementary pairs non-overlapping inverses
// - Match fires when the counter leaves value
// - Equal A and B leave output unchanged
`timescale 1ns/1ps
module tpw_top
	import tpw_pkg::*;
#(
	parameter int W   = TPW_W,
	parameter int NCH = TPW_NCH
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	input  wire logic [TPW_ADDR_W-1:0] addr,
	input  wire logic [W-1:0]          wdata,
	input  wire logic                  wstb,
	input  wire logic                  rstb,
	output logic      [W-1:0]          rdata,
	input  wire logic [TPW_NEXT-1:0]   ext_clk,
	output logic      [NCH-1:0]        compare_pin_a_out,
	output logic      [NCH-1:0]        compare_pin_a_oe,
	output logic      [NCH-1:0]        compare_pin_b_out,
	output logic      [NCH-1:0]        compare_pin_b_oe,
	output logic                       pair2_negative_pin,
	output logic                       pair2_negative_oe,
	output logic                       pair3_negative_pin,
	output logic                       pair3_negative_oe
);

	// ==========================================================
	// Register storage
	// ==========================================================
	logic [6:0]     ctrl [NCH];  // timer_control_reg per channel.
	logic [3:0]     io   [NCH];  // io_control_reg per channel.
	logic [W-1:0]   general_reg_a  [NCH];  // general_reg_a per channel.
	logic [W-1:0]   general_reg_b  [NCH];  // general_reg_b per channel.
	logic [NCH-1:0] run_bits;    // timer_start_reg.
	logic [NCH-1:0] pwm_mode;    // timer_mode_reg.
	tpw_cmb_t       cmb;         // combination_mode_reg.

	// ==========================================================
	// Address decode
	// ==========================================================
	wire logic [2:0] a_ch  = addr[5:3];
	wire logic [2:0] a_reg = addr[2:0];
	wire logic       a_chv = (32'(a_ch) < NCH);
	wire logic       wr_start = wstb & (addr == TPW_OFF_START);
	wire logic       wr_mode  = wstb & (addr == TPW_OFF_MODE);
	wire logic       wr_comb  = wstb & (addr == TPW_OFF_COMB);

	// ==========================================================
	// Prescaler and external edge detection
	// ==========================================================
	logic [2:0]          pre;       // Free-running divide-by-8 phase.
	logic [TPW_NEXT-1:0] ext_prev;  // Last sampled level of each external input.
	wire logic [TPW_NEXT-1:0] ext_rise = ext_clk & ~ext_prev;
	wire logic [TPW_NEXT-1:0] ext_fall = ~ext_clk & ext_prev;

	// The prescaler is shared so channels on the same rate tick together.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pre      <= 3'h0;
			ext_prev <= '0;
		end else begin
			pre      <= 3'(pre + 3'h1);
			ext_prev <= ext_clk;
		end
	end

	// ==========================================================
	// Mode decode
	// ==========================================================
	wire logic rsync    = (cmb == TPW_CMB_RSYNC);
	wire logic compl_md = (cmb == TPW_CMB_COMPL);
	wire logic pair_md  = rsync | compl_md;

	// ==========================================================
	// Channels
	// ==========================================================
	logic [W-1:0]   cnt [NCH];
	logic [NCH-1:0] tick;
	logic [NCH-1:0] match_a;
	logic [NCH-1:0] match_b;
	logic [NCH-1:0] clr_own;
	logic [NCH-1:0] pwm_q;  // PWM waveform state per channel.
	logic [NCH-1:0] pa_q;   // Plain compare output on pin A.
	logic [NCH-1:0] pb_q;   // Plain compare output on pin B.
	wire logic      sync_clr = |clr_own;

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : gen_ch
			wire logic cnt_wr = wstb & a_chv & (32'(a_ch) == g) & (a_reg == TPW_OFF_CNT);
			wire logic wr_any = wstb & a_chv & (32'(a_ch) == g);
			wire tpw_of_t fa = tpw_of_t'(io[g][TPW_IOA_LSB +: 2]);
			wire tpw_of_t fb = tpw_of_t'(io[g][TPW_IOB_LSB +: 2]);
			wire logic    eq = (general_reg_a[g] == general_reg_b[g]);
			// PWM: A sets, B clears, equal registers hold the level.
			wire logic next_pwm = eq ? pwm_q[g] :
			                      match_a[g] ? 1'b1 : match_b[g] ? 1'b0 : pwm_q[g];
			wire logic next_pa = !match_a[g] ? pa_q[g] : (fa == TPW_OF_ZERO) ? 1'b0 :
			                     (fa == TPW_OF_ONE) ? 1'b1 : (fa == TPW_OF_TOGGLE) ? ~pa_q[g] : pa_q[g];
			wire logic next_pb = !match_b[g] ? pb_q[g] : (fb == TPW_OF_ZERO) ? 1'b0 :
			                     (fb == TPW_OF_ONE) ? 1'b1 : (fb == TPW_OF_TOGGLE) ? ~pb_q[g] : pb_q[g];

			tpw_chan #(.W(W)) u_chan (
				.ref_clk     (ref_clk),
				.rst         (rst),
				.ctrl        (ctrl[g]),
				.pre         (pre),
				.ext_rise    (ext_rise),
				.ext_fall    (ext_fall),
				.run         (run_bits[g]),
				.force_clr_a ((g == 3) && rsync),
				.sync_clr_in (sync_clr),
				.cnt_wr      (cnt_wr),
				.wdata       (wdata),
				.general_reg_a         (general_reg_a[g]),
				.general_reg_b         (general_reg_b[g]),
				.cnt         (cnt[g]),
				.tick        (tick[g]),
				.match_a     (match_a[g]),
				.match_b     (match_b[g]),
				.clr_own     (clr_own[g])
			);

			// Per-channel software registers and compare outputs.
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					ctrl[g]  <= TPW_CTRL_RST;
					io[g]    <= TPW_IO_RST;
					general_reg_a[g]   <= TPW_GR_RST;
					general_reg_b[g]   <= TPW_GR_RST;
					pwm_q[g] <= 1'b0;
					pa_q[g]  <= 1'b0;
					pb_q[g]  <= 1'b0;
				end else begin
					if (wr_any && a_reg == TPW_OFF_CTRL) ctrl[g] <= wdata[6:0];
					if (wr_any && a_reg == TPW_OFF_IO)   io[g]   <= wdata[3:0];
					if (wr_any && a_reg == TPW_OFF_GRA)  general_reg_a[g]  <= wdata;
					if (wr_any && a_reg == TPW_OFF_GRB)  general_reg_b[g]  <= wdata;
					pwm_q[g] <= pwm_mode[g] ? next_pwm : 1'b0;
					pa_q[g]  <= next_pa;
					pb_q[g]  <= next_pb;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Channel 3/4 pair engine
	// ==========================================================
	// All three pairs follow counter 3; counter 4 keeps counting on its
	// own but its matches never reach the pair outputs.
	logic [2:0] pos_q;  // Positive phase of pairs 1 to 3.
	logic [2:0] pos_d;  // One-cycle delayed copy for the non-overlap gap.
	wire logic       clr3 = tick[3] & (cnt[3] == general_reg_a[3]);
	wire logic [2:0] turn = {tick[3] & (cnt[3] == general_reg_b[4]),
	                         tick[3] & (cnt[3] == general_reg_a[4]),
	                         tick[3] & (cnt[3] == general_reg_b[3])};
	// A turning point equal to the period toggles twice in one edge and
	// so holds its level; software keeps turns at or below the period.
	// Any write to the combination mode register restarts every pair from its low phase, but counter 3
	// keeps its count, so a switch between pair modes leaves a pair in step only if counter 3 is restarted too.
	wire logic [2:0] next_pos = (pair_md && !wr_comb) ? (pos_q ^ turn ^ {3{clr3}}) : 3'h0;
	// Complementary mode opens a one-cycle gap so the pair never overlaps.
	wire logic [2:0] neg = compl_md ? (~pos_q & ~pos_d) : ~pos_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pos_q <= 3'h0;
			pos_d <= 3'h0;
		end else begin
			pos_q <= next_pos;
			pos_d <= pos_q;
		end
	end

	// ==========================================================
	// Global registers
	// ==========================================================
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			run_bits <= '0;
			pwm_mode <= '0;
			cmb      <= TPW_CMB_NORMAL;
		end else begin
			if (wr_start) run_bits <= wdata[NCH-1:0];
			if (wr_mode)  pwm_mode <= wdata[NCH-1:0];
			if (wr_comb)  cmb      <= tpw_cmb_t'(wdata[1:0]);
		end
	end

	// ==========================================================
	// Read path
	// ==========================================================
	wire logic [2:0] rch = a_chv ? a_ch : 3'h0;
	wire logic [W-1:0] ch_rd = (a_reg == TPW_OFF_CTRL) ? W'(ctrl[rch]) :
	                           (a_reg == TPW_OFF_IO)   ? W'(io[rch])   :
	                           (a_reg == TPW_OFF_CNT)  ? cnt[rch]      :
	                           (a_reg == TPW_OFF_GRA)  ? general_reg_a[rch]      :
	                           (a_reg == TPW_OFF_GRB)  ? general_reg_b[rch]      : '0;
	wire logic [W-1:0] rd_mux = a_chv ? ch_rd :
	                            (addr == TPW_OFF_START) ? W'(run_bits) :
	                            (addr == TPW_OFF_MODE)  ? W'(pwm_mode) :
	                            (addr == TPW_OFF_COMB)  ? W'(cmb)      : '0;

	// Read data stand only in the cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else begin
			rdata <= rstb ? rd_mux : '0;
		end
	end

	// ==========================================================
	// Pin multiplexing
	// ==========================================================
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			compare_pin_a_out[i] = pwm_mode[i] ? pwm_q[i] : pa_q[i];
			compare_pin_a_oe[i]  = pwm_mode[i] | (io[i][TPW_IOA_LSB +: 2] != 2'b00);
			compare_pin_b_out[i] = pb_q[i];
			compare_pin_b_oe[i]  = (io[i][TPW_IOB_LSB +: 2] != 2'b00);
		end
		if (pair_md) begin
			compare_pin_a_out[3] = pos_q[0];
			compare_pin_b_out[3] = neg[0];
			compare_pin_a_out[4] = pos_q[1];
			compare_pin_b_out[4] = pos_q[2];
			compare_pin_a_oe[3]  = 1'b1;
			compare_pin_b_oe[3]  = 1'b1;
			compare_pin_a_oe[4]  = 1'b1;
			compare_pin_b_oe[4]  = 1'b1;
		end
	end
	assign pair2_negative_pin = pair_md & neg[1];
	assign pair3_negative_pin = pair_md & neg[2];
	assign pair2_negative_oe  = pair_md;
	assign pair3_negative_oe  = pair_md;

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_pwm_goes_high: assert property ((pwm_mode[0] && match_a[0] && !match_b[0] && general_reg_a[0] != general_reg_b[0])
		|=> compare_pin_a_out[0]) else $error("pwm output not high after match A");
	chk_pwm_goes_low: assert property ((pwm_mode[1] && match_b[1] && general_reg_a[1] != general_reg_b[1])
		|=> !compare_pin_a_out[1]) else $error("pwm output not low after match B");
	chk_pwm_equal_hold: assert property ((pwm_mode[0] && pwm_mode[0] == $past(pwm_mode[0]) && general_reg_a[0] == general_reg_b[0])
		|=> $stable(pwm_q[0])) else $error("pwm output moved with equal registers");
	chk_pwm_rise_cause: assert property ((pwm_mode[2] && $past(pwm_mode[2]) && $rose(pwm_q[2]))
		|-> $past(tick[2] && cnt[2] == general_reg_a[2])) else $error("pwm rose without leaving match A");
	chk_zero_duty_low: assert property ((pwm_mode[1] && ctrl[1][TPW_CLR_LSB +: 2] == TPW_CLR_B && general_reg_a[1] > general_reg_b[1]
		&& cnt[1] <= general_reg_b[1] && !pwm_q[1] && !wstb) |=> !pwm_q[1]) else $error("zero duty output went high");
	chk_full_duty_high: assert property ((pwm_mode[2] && ctrl[2][TPW_CLR_LSB +: 2] == TPW_CLR_A && general_reg_b[2] > general_reg_a[2]
		&& cnt[2] <= general_reg_a[2] && pwm_q[2] && !wstb) |=> pwm_q[2]) else $error("full duty output went low");
	chk_pin_b_free: assert property ((pwm_mode[1] && io[1][TPW_IOB_LSB +: 2] == 2'b00)
		|-> !compare_pin_b_oe[1]) else $error("pin B driven without its own function");
	chk_rsync_inverse: assert property (rsync |-> (compare_pin_b_out[3] == !compare_pin_a_out[3]
		&& pair2_negative_pin == !compare_pin_a_out[4] && pair3_negative_pin == !compare_pin_b_out[4]))
		else $error("reset-sync pair not inverted");
	chk_rsync_period: assert property ((rsync && $past(rsync) && clr3 && !wstb) |=> cnt[3] == '0)
		else $error("counter 3 not cleared at period");
	chk_turn_toggle: assert property ((rsync && $past(rsync) && rsync == $past(rsync, 2) && turn[0] && !clr3 && !wr_comb)
		|=> pos_q[0] != $past(pos_q[0])) else $error("pair 1 did not toggle at turn");
	chk_pair_oe: assert property (pair_md |-> (&compare_pin_a_oe[4:3] && &compare_pin_b_oe[4:3]
		&& pair2_negative_oe && pair3_negative_oe)) else $error("pair pins not driven");
	chk_compl_gap: assert property (compl_md |-> !(compare_pin_a_out[3] && compare_pin_b_out[3]))
		else $error("complementary pair overlaps");

	cov_pwm_cycle: cover property (pwm_mode[0] && match_a[0] ##[1:200] match_b[0]);
	cov_rsync_clear: cover property (rsync && clr3);
	cov_compl_turn: cover property (compl_md && turn[1]);
	cov_read_back: cover property (rstb ##1 rdata != '0);

endmodule : tpw_top

// ### verif/tpw_load.sv
/*
 * Load model: a power stage watching eight PWM lines and timing them.
 * Assumes every line is an output of the block, synchronous to ref_clk.
 */
`timescale 1ns/1ps
module tpw_load (
	input  wire logic        ref_clk,
	input  wire logic        restart,
	input  wire logic [7:0]  line,
	output logic      [15:0] hi_len [8],
	output logic      [15:0] lo_len [8],
	output logic             overlap
);
	// ==========================================================
	// Span timing
	// ==========================================================
	logic [7:0]  prev;     // Levels seen at the previous edge.
	logic [15:0] run [8];  // Cycles spent at the present level.
	// Record the last completed high and low span of each line.
	// A shoot-through on any of the pairs 2/3, 4/5 and 6/7 is remembered until the next restart.
	always @(posedge ref_clk) begin
		for (int i = 0; i < 8; i++) begin
			if (restart) begin
				run[i] <= 16'h0000;
				hi_len[i] <= 16'h0000;
				lo_len[i] <= 16'h0000;
			end else if (line[i] !== prev[i]) begin
				run[i] <= 16'h0001;
				if (prev[i]) hi_len[i] <= run[i];
				else lo_len[i] <= run[i];
			end else begin
				run[i] <= run[i] + 16'h0001;
			end
		end
		prev <= line;
		overlap <= !restart && (overlap || (line[2] && line[3]) || (line[4] && line[5]) || (line[6] && line[7]));
	end
endmodule : tpw_load

// ### verif/tpw_top_tb.sv
/*
 * Testbench of the timer PWM output block: register tasks, PWM and pair modes.
 * Assumes the register map and encodings of the block's package.
 */
`timescale 1ns/1ps
module tpw_top_tb;
	import tpw_pkg::*;
	logic        ref_clk, rst, wstb, rstb, restart, n2, n2_oe, n3, n3_oe, overlap;
	logic [5:0]  addr;
	logic [15:0] wdata, rdata, got;
	logic [3:0]  ext_clk;
	logic [1:0]  xc;
	logic [4:0]  pa, pa_oe, pb, pb_oe;
	logic [15:0] hi_len [8];
	logic [15:0] lo_len [8];
	logic [6:0]  cfg [4] = '{7'h40, 7'h44, 7'h4C, 7'h54};  // Sys, ext rise, ext fall, ext both.
	int          mult [4] = '{1, 4, 4, 2};                  // System cycles per count.
	int          turn [3] = '{3, 6, 8};                     // Turning points of the three pairs.
	int          n_fail, n_checks;
	tpw_top dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wstb(wstb), .rstb(rstb),
		.rdata(rdata), .ext_clk(ext_clk), .compare_pin_a_out(pa), .compare_pin_a_oe(pa_oe),
		.compare_pin_b_out(pb), .compare_pin_b_oe(pb_oe), .pair2_negative_pin(n2),
		.pair2_negative_oe(n2_oe), .pair3_negative_pin(n3), .pair3_negative_oe(n3_oe));
	tpw_load load (.ref_clk(ref_clk), .restart(restart), .line({n3, pb[4], n2, pa[4], pb[3], pa[3], pb[0], pa[0]}),
		.hi_len(hi_len), .lo_len(lo_len), .overlap(overlap));
	// ==========================================================
	// Clock and external count source
	// ==========================================================
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// External inputs toggle every two cycles, wide enough for both-edge counting.
	always @(posedge ref_clk) begin
		xc <= xc + 2'h1;
		if (xc[0]) ext_clk <= ~ext_clk;
	end
	// ==========================================================
	// Tasks
	// ==========================================================
	function automatic logic [5:0] ra(input logic [2:0] ch, input logic [2:0] off);
		return {ch, off};
	endfunction : ra
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wstb <= 1'b1;
		@(posedge ref_clk);
		wstb <= 1'b0;
	endtask : wr
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Read data stand only in the cycle after the strobe, so sample mid-cycle.
	task automatic rd_check(input logic [5:0] a, input logic [15:0] exp, input string what);
		@(posedge ref_clk);
		addr <= a;
		rstb <= 1'b1;
		@(posedge ref_clk);
		rstb <= 1'b0;
		@(negedge ref_clk);
		check(what, exp, rdata);
	endtask : rd_check
	// Restart the load's timers, then let several periods pass.
	task automatic settle(input int n);
		@(posedge ref_clk);
		restart <= 1'b1;
		@(posedge ref_clk);
		restart <= 1'b0;
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : settle
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	// ==========================================================
	// Tests
	// ==========================================================
	initial begin
		{rst, wstb, rstb, restart, addr, wdata, ext_clk, xc, n_fail, n_checks} = '0;
		rst = 1'b1;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		rd_check(ra(0, TPW_OFF_GRA), TPW_GR_RST, "gra0 reset");
		rd_check(ra(0, TPW_OFF_CNT), TPW_CNT_RST, "cnt0 reset");
		wr(ra(1, TPW_OFF_GRB), 16'hA5C3);
		rd_check(ra(1, TPW_OFF_GRB), 16'hA5C3, "grb1 full width");
		rd_check(6'h3F, 16'h0000, "unmapped read");
		$display("test bus done");
		// Channel 1 aims at 0% and channel 2 at 100% while channel 0 runs PWM.
		wr(ra(1, TPW_OFF_CTRL), 16'h0040);
		wr(ra(1, TPW_OFF_GRA), 16'h0007);
		wr(ra(1, TPW_OFF_GRB), 16'h0004);
		wr(ra(2, TPW_OFF_CTRL), 16'h0020);
		wr(ra(2, TPW_OFF_GRA), 16'h0004);
		wr(ra(2, TPW_OFF_GRB), 16'h0007);
		wr(ra(0, TPW_OFF_IO), 16'h0007);
		for (int k = 0; k < 4; k++) begin
			wr(TPW_OFF_START, 16'h0000);
			wr(ra(0, TPW_OFF_CNT), 16'h0000);
			wr(ra(0, TPW_OFF_CTRL), 16'(cfg[k]));
			wr(ra(0, TPW_OFF_GRA), 16'h0002);
			wr(ra(0, TPW_OFF_GRB), 16'h0005);
			wr(TPW_OFF_MODE, 16'h0007);
			wr(TPW_OFF_START, 16'h0007);
			settle(120);
			check("pwm high span", 16'(3 * mult[k]), hi_len[0]);
			check("pwm low span", 16'(3 * mult[k]), lo_len[0]);
			check("pin b span", 16'(6 * mult[k]), hi_len[1]);
			check("pin a enable", 16'h0001, 16'(pa_oe[0]));
			check("pin b enable", 16'h0001, 16'(pb_oe[0]));
		end
		check("zero duty", 16'h0000, 16'(pa[1]));
		check("full duty", 16'h0001, 16'(pa[2]));
		// Equal registers: matches may still clear the counter, but the pin must hold.
		wr(ra(0, TPW_OFF_GRB), 16'h0002);
		settle(20);
		check("equal hold", 16'h0000, hi_len[0] | lo_len[0]);
		$display("test pwm done");
		wr(TPW_OFF_START, 16'h0000);
		wr(ra(3, TPW_OFF_CTRL), 16'h0020);
		wr(TPW_OFF_COMB, 16'h0001);
		wr(ra(3, TPW_OFF_CNT), 16'h0000);
		wr(ra(3, TPW_OFF_GRA), 16'h0009);
		wr(ra(3, TPW_OFF_GRB), 16'(turn[0]));
		wr(ra(4, TPW_OFF_GRA), 16'(turn[1]));
		wr(ra(4, TPW_OFF_GRB), 16'(turn[2]));
		wr(TPW_OFF_START, 16'h0018);
		settle(60);
		for (int j = 0; j < 3; j++) begin
			check("pair high span", 16'(9 - turn[j]), hi_len[2 + 2 * j]);
			check("pair low span", 16'(turn[j] + 1), lo_len[2 + 2 * j]);
			check("inverse high span", 16'(turn[j] + 1), hi_len[3 + 2 * j]);
		end
		check("pair enables", 16'h003F, {10'h000, pa_oe[4:3], pb_oe[4:3], n2_oe, n3_oe});
		check("pair overlap", 16'h0000, 16'(overlap));
		$display("test reset sync done");
		wr(TPW_OFF_START, 16'h0000);
		wr(TPW_OFF_COMB, 16'h0002);
		wr(ra(3, TPW_OFF_CNT), 16'h0000);
		wr(TPW_OFF_START, 16'h0018);
		settle(60);
		for (int j = 0; j < 3; j++)
			check("gapped inverse span", 16'(turn[j]), hi_len[3 + 2 * j]);
		check("pair enables", 16'h003F, {10'h000, pa_oe[4:3], pb_oe[4:3], n2_oe, n3_oe});
		check("pair overlap", 16'h0000, 16'(overlap));
		$display("test complementary done");
		report_and_stop();
	end
	// The tests take under 3000 cycles; a hang is cut well beyond that.
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		report_and_stop();
	end
endmodule : tpw_top_tb
